// ==== shared/ret_rot_pkg.sv ====
// Function
// - A return opcode pops the return stack and loads the popped head into the program counter, one word, two cycles.
// - With the fast-return bit set, the shadow accumulator, flags and bank pointer are copied to the live registers.
// - With the fast-return bit clear, accumulator, flags and bank pointer are left untouched.
// - A return leaves both program counter latches alone and changes no flag beyond a shadow restore.
// - A rotate-left-through-carry shifts each bit up one, old bit 7 to carry, old carry to bit 0, updating C, N, Z.
// - A rotate with destination bit 0 writes the accumulator, with 1 writes back to the file register.
// - A rotate with access bit 0 addresses the access bank, with 1 the bank chosen by the bank pointer.
package ret_rot_pkg;
    // ****************************************
    // opcode patterns
    // ****************************************
    localparam logic [14:0] RET_OPC = 15'h0009;   // 0000 0000 0001 001s
    localparam logic [5:0] ROT_OPC = 6'h0d;       // 0011 01da
    localparam int RET_D_BIT = 0;
    localparam int ROT_D_BIT = 9;
    localparam int ROT_A_BIT = 8;
    // ****************************************
    // flag positions and timing
    // ****************************************
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 2;
    localparam int FLAG_N = 4;
    localparam int Q_PER_CYCLE = 4;
    localparam logic [1:0] Q4 = 2'h3;
    localparam logic [1:0] RET_CYCLES = 2'h2;
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [3:0] BANK_RST = 4'h0;
    localparam logic [3:0] ACCESS_BANK_LO = 4'h0;
    localparam logic [3:0] ACCESS_BANK_HI = 4'hf;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    typedef enum logic [1:0] {ST_FETCH = 2'b00, ST_RET2 = 2'b01} exec_state_t;
endpackage

// ==== src/return_and_rotate_carry_exec.sv ====
module return_and_rotate_carry_exec
    import ret_rot_pkg::*;
#(
    parameter int PC_W = 21
)
(
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // instruction
    input wire logic instr_valid,
    input wire logic [15:0] instr,
    // return stack
    input wire logic [PC_W-1:0] return_stack_head,
    output logic stack_pop,
    // file memory
    input wire logic [7:0] file_rdata,
    output logic [11:0] file_addr,
    output logic [7:0] file_wdata,
    output logic file_we,
    // shadow inputs
    input wire logic [7:0] shadow_accumulator,
    input wire logic [7:0] shadow_flags_reg,
    input wire logic [3:0] shadow_bank_pointer,
    // latch inputs, passed through unmodified
    input wire logic [7:0] prog_counter_upper_latch_in,
    input wire logic [7:0] prog_counter_high_latch_in,
    // architectural state
    output logic [PC_W-1:0] pc,
    output logic [7:0] accumulator,
    output logic [7:0] flags,
    output logic [3:0] bank_pointer,
    output logic [7:0] prog_counter_upper_latch,
    output logic [7:0] prog_counter_high_latch,
    output logic busy,
    output logic [1:0] qphase
);
    // ****************************************
    // decode
    // ****************************************
    logic [1:0] q_r;
    exec_state_t st_r;
    logic is_ret;
    logic is_rot;
    logic [7:0] rot_res;
    logic rot_c;
    logic rot_n;
    logic rot_z;
    logic [3:0] bank_sel;
    logic [7:0] flags_nxt;
    logic [PC_W-1:0] pc_r;

    function automatic logic [3:0] pick_bank(input logic a, input logic [7:0] f, input logic [3:0] bp);
        if (a)
            pick_bank = bp;
        else
            pick_bank = (f < ACCESS_SPLIT) ? ACCESS_BANK_LO : ACCESS_BANK_HI;
    endfunction

    // only a decode slot in the fetch state starts an instruction
    assign is_ret = instr_valid && st_r == ST_FETCH && instr[15:1] == RET_OPC;
    assign is_rot = instr_valid && st_r == ST_FETCH && instr[15:10] == ROT_OPC;
    assign bank_sel = pick_bank(instr[ROT_A_BIT], instr[7:0], bank_pointer);

    rot_carry_alu u_alu
    (
        .src(file_rdata),
        .carry_in(flags[FLAG_C]),
        .res(rot_res),
        .carry_out(rot_c),
        .neg(rot_n),
        .zero(rot_z)
    );

    always_comb
    begin
        flags_nxt = flags;
        flags_nxt[FLAG_C] = rot_c;
        flags_nxt[FLAG_N] = rot_n;
        flags_nxt[FLAG_Z] = rot_z;
    end

    // ****************************************
    // q-phase counter and sequencing
    // ****************************************
    // four core clocks per instruction cycle; work commits at the last phase
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            q_r <= 2'h0;
        else
            q_r <= q_r + 2'h1;
    end

    // the return occupies a second, empty instruction cycle
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            st_r <= ST_FETCH;
        else if (q_r == Q4)
        begin
            if (is_ret)
                st_r <= ST_RET2;
            else
                st_r <= ST_FETCH;
        end
    end

    // ****************************************
    // architectural registers
    // ****************************************
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            pc_r <= '0;
        else if (q_r == Q4 && is_ret)
            pc_r <= return_stack_head;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
            stack_pop <= 1'b0;
        else
            stack_pop <= (q_r == Q4) && is_ret;
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            accumulator <= ACC_RST;
            flags <= FLAGS_RST;
            bank_pointer <= BANK_RST;
        end
        else if (q_r == Q4 && is_ret && instr[RET_D_BIT])
        begin
            accumulator <= shadow_accumulator;
            flags <= shadow_flags_reg;
            bank_pointer <= shadow_bank_pointer;
        end
        else if (q_r == Q4 && is_rot)
        begin
            flags <= flags_nxt;
            if (!instr[ROT_D_BIT])
                accumulator <= rot_res;
        end
        // fast bit clear on return: nothing written here
    end

    // file write enable is set at the last phase and pulses for the clock after it, address stable from decode on
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            file_addr <= 12'h000;
            file_wdata <= 8'h00;
            file_we <= 1'b0;
        end
        else
        begin
            file_addr <= {bank_sel, instr[7:0]};
            file_wdata <= rot_res;
            file_we <= (q_r == Q4) && is_rot && instr[ROT_D_BIT];
        end
    end

    // latches only follow their own inputs; a return never touches them
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            prog_counter_upper_latch <= 8'h00;
            prog_counter_high_latch <= 8'h00;
        end
        else
        begin
            prog_counter_upper_latch <= prog_counter_upper_latch_in;
            prog_counter_high_latch <= prog_counter_high_latch_in;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            busy <= 1'b0;
            qphase <= 2'h0;
        end
        else
        begin
            busy <= (st_r == ST_RET2);
            qphase <= q_r + 2'h1;
        end
    end

    assign pc = pc_r;

    // ****************************************
    // checks
    // ****************************************
    AST_RET_PC: assert property (@(posedge core_clk) disable iff (!arst_n)
        (q_r == Q4 && is_ret) |=> (pc == $past(return_stack_head) && stack_pop))
        else $error("return did not load pc");
    AST_RET_TWO_CYC: assert property (@(posedge core_clk) disable iff (!arst_n)
        (q_r == Q4 && is_ret) |=> (st_r == ST_RET2) [*4] ##1 (st_r == ST_FETCH))
        else $error("return not two cycles");
    AST_FAST_RESTORE: assert property (@(posedge core_clk) disable iff (!arst_n)
        (q_r == Q4 && is_ret && instr[RET_D_BIT]) |=> (bank_pointer == $past(shadow_bank_pointer)
        && accumulator == $past(shadow_accumulator) && flags == $past(shadow_flags_reg)))
        else $error("shadow restore missed");
    AST_SLOW_KEEP: assert property (@(posedge core_clk) disable iff (!arst_n)
        (q_r == Q4 && is_ret && !instr[RET_D_BIT]) |=> ($stable(accumulator) && $stable(flags)
        && $stable(bank_pointer)))
        else $error("slow return changed state");
    AST_LATCH_KEEP: assert property (@(posedge core_clk) disable iff (!arst_n)
        is_ret |=> (prog_counter_high_latch == $past(prog_counter_high_latch_in)
        && prog_counter_upper_latch == $past(prog_counter_upper_latch_in)))
        else $error("latch altered");
    AST_ROT_CARRY: assert property (@(posedge core_clk) disable iff (!arst_n)
        (q_r == Q4 && is_rot) |=> (flags[FLAG_C] == $past(file_rdata[7])))
        else $error("carry wrong");
    AST_ROT_DEST: assert property (@(posedge core_clk) disable iff (!arst_n)
        (q_r == Q4 && is_rot && !instr[ROT_D_BIT]) |=> (!file_we && accumulator[0] == $past(flags[FLAG_C])))
        else $error("destination wrong");
    AST_ROT_BANK: assert property (@(posedge core_clk) disable iff (!arst_n)
        (is_rot && instr[ROT_A_BIT]) |=> (file_addr[11:8] == $past(bank_pointer)))
        else $error("bank wrong");
    AST_ROT_NZ: assert property (@(posedge core_clk) disable iff (!arst_n)
        (q_r == Q4 && is_rot) |=> (flags[FLAG_Z] == ($past(file_rdata[6:0]) == 7'h00 && !$past(flags[FLAG_C]))
        && flags[FLAG_N] == $past(file_rdata[6])))
        else $error("zero flag wrong");
endmodule

// ==== src/rot_carry_alu.sv ====
module rot_carry_alu
    import ret_rot_pkg::*;
(
    // operand in
    input wire logic [7:0] src,
    input wire logic carry_in,
    // result out
    output logic [7:0] res,
    output logic carry_out,
    output logic neg,
    output logic zero
);
    // rotate through carry and derive flags
    always_comb
    begin
        res = {src[6:0], carry_in};
        carry_out = src[7];
        neg = res[7];
        zero = (res == 8'h00);
    end
endmodule

// ==== verification/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ret_rot_pkg::*;
    // ****************************************
    // stimulus, observed outputs and bookkeeping
    // ****************************************
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr = 16'h0000;
    logic [20:0] head = 21'h000000;
    logic [7:0] sh_acc = 8'h00, sh_flags = 8'h00, lat_u = 8'h00, lat_h = 8'h00;
    logic [3:0] sh_bank = 4'h0;
    logic [7:0] mem [4096];
    logic [7:0] e_mem [4096];
    logic [7:0] file_rdata, file_wdata, accumulator, flags, pcu, pch;
    logic [11:0] file_addr;
    logic [20:0] pc;
    logic [3:0] bank_pointer;
    logic [1:0] qphase;
    logic stack_pop, file_we, busy;
    logic [7:0] e_acc = ACC_RST, e_flags = FLAGS_RST;
    logic [3:0] e_bank = BANK_RST;
    logic [19:0] q_wr[$];
    logic [20:0] q_pc[$];
    int errors = 0, compares = 0, cycles = 0, seed = 32'h77a6;

    always #2.5 core_clk = ~core_clk;
    // memory answers combinationally, as the core expects
    assign file_rdata = mem[file_addr];

    // the core's write-back lands in the memory it reads; the model keeps its own copy
    always @(posedge core_clk)
    begin
        if (file_we === 1'b1)
            mem[file_addr] <= file_wdata;
    end

    return_and_rotate_carry_exec #(.PC_W(21)) i_dut (.core_clk(core_clk), .arst_n(arst_n),
        .instr_valid(instr_valid), .instr(instr), .return_stack_head(head), .stack_pop(stack_pop),
        .file_rdata(file_rdata), .file_addr(file_addr), .file_wdata(file_wdata), .file_we(file_we),
        .shadow_accumulator(sh_acc), .shadow_flags_reg(sh_flags), .shadow_bank_pointer(sh_bank),
        .prog_counter_upper_latch_in(lat_u), .prog_counter_high_latch_in(lat_h), .pc(pc),
        .accumulator(accumulator), .flags(flags), .bank_pointer(bank_pointer),
        .prog_counter_upper_latch(pcu), .prog_counter_high_latch(pch), .busy(busy), .qphase(qphase));

    task check(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (e !== g)
        begin
            errors++;
            $display("Error at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task check_wr(input logic [31:0] e, input logic [31:0] g);
        check(e, g);
    endtask

    task check_pc(input logic [31:0] e, input logic [31:0] g);
        check(e, g);
    endtask

    task conclude;
        if (errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // a hang must end in the same report; the run needs about 850 cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            conclude();
        end
    end

    // ****************************************
    // watcher: pulses take the oldest note
    // ****************************************
    always @(posedge core_clk)
    begin
        if (arst_n && file_we === 1'b1)
            check_wr(q_wr.size() > 0 ? q_wr.pop_front() : 32'hffffffff, {file_addr, file_wdata});
        if (arst_n && stack_pop === 1'b1)
            check_pc(q_pc.size() > 0 ? q_pc.pop_front() : 32'hffffffff, pc);
    end

    // one instruction: present the word, note the outcome, then check state
    task run_one(input logic [15:0] w);
        logic [11:0] addr;
        logic [7:0] src, res;
        begin
            do
            begin
                @(posedge core_clk);
                #1;
            end while (!(qphase === 2'h0 && busy === 1'b0));
            {head, sh_acc, sh_flags, sh_bank} = 41'({$random(seed), $random(seed)});
            {lat_u, lat_h} = 16'($random(seed));
            instr = w;
            instr_valid = 1'b1;
            if (w[15:1] == RET_OPC)
            begin
                q_pc.push_back(head);
                if (w[RET_D_BIT])
                    {e_acc, e_flags, e_bank} = {sh_acc, sh_flags, sh_bank};
            end
            else
            begin
                addr = w[ROT_A_BIT] ? {e_bank, w[7:0]} :
                    {(w[7:0] >= ACCESS_SPLIT) ? ACCESS_BANK_HI : ACCESS_BANK_LO, w[7:0]};
                src = e_mem[addr];
                res = {src[6:0], e_flags[FLAG_C]};
                e_flags[FLAG_C] = src[7];
                e_flags[FLAG_N] = res[7];
                e_flags[FLAG_Z] = (res == 8'h00);
                if (w[ROT_D_BIT])
                begin
                    q_wr.push_back({addr, res});
                    e_mem[addr] = res;
                end
                else
                    e_acc = res;
            end
            do
            begin
                @(posedge core_clk);
                #1;
            end while (qphase !== Q4);
            @(posedge core_clk);
            #1;
            instr_valid = 1'b0;
            repeat (2) @(posedge core_clk);
            #1;
            check(e_acc, accumulator);
            check(e_flags, flags);
            check(e_bank, bank_pointer);
            check({lat_u, lat_h}, {pcu, pch});
            check(w[15:1] == RET_OPC, busy);
        end
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        for (int i = 0; i < 4096; i++)
        begin
            mem[i] = 8'($random(seed));
            e_mem[i] = mem[i];
        end
        mem[12'h005] = 8'h80;
        e_mem[12'h005] = 8'h80;
        repeat (6) @(posedge core_clk);
        #1;
        arst_n = 1'b1;
        check({ACC_RST, FLAGS_RST, BANK_RST}, {accumulator, flags, bank_pointer});
        // carry out with a zero result, then the carry comes back in at bit 0
        run_one({ROT_OPC, 1'b0, 1'b0, 8'h05});
        run_one({ROT_OPC, 1'b1, 1'b0, 8'h05});
        run_one({RET_OPC, 1'b1});
        run_one({ROT_OPC, 1'b1, 1'b1, 8'hc3});
        // randomly interleaved returns and rotates of every operand form, each after an idle instruction cycle
        for (int n = 0; n < 80; n++)
            run_one($random(seed) & 32'h1 ? {RET_OPC, 1'($random(seed))} : {ROT_OPC, 10'($random(seed))});
        repeat (8) @(posedge core_clk);
        check(32'h0, q_wr.size() + q_pc.size());
        conclude();
    end
endmodule
